// ### design/adc_sample_output_pipeline.sv
/*
 * Digital model of an 8-bit sampling converter: divided converter clock,
 * sampling on its falling edge, clamp to the reference window, pipeline to
 * the parallel output port with high-impedance control, and a capture FIFO copy.
 * Assumes all inputs are synchronous to sys_clk and the analog level is
 * given as an unsigned fraction of the reference.
 */
`include "adc_pipe_consts.svh"
`timescale 1ns/10ps

module capture_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] wr_ptr_nxt;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W-1:0] rd_ptr_nxt;
    logic [PTR_W:0]   count_r;
    logic [PTR_W:0]   count_nxt;
    logic             push;
    logic             pop;
    logic             in_ready_r;
    logic             in_ready_nxt;
    logic             out_valid_r;
    logic             out_valid_nxt;
    logic [WIDTH-1:0] out_data_r;
    logic [WIDTH-1:0] out_data_nxt;

    // Flags and head word are registered so the ports come straight from flops
    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
    assign push      = in_valid && in_ready_r;
    assign pop       = out_valid_r && out_ready;

    // Pointer, count and registered flag update
    always_comb begin
        wr_ptr_nxt    = push ? wr_ptr_r + PTR_W'(1) : wr_ptr_r;
        rd_ptr_nxt    = pop ? rd_ptr_r + PTR_W'(1) : rd_ptr_r;
        count_nxt     = count_r + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        in_ready_nxt  = (count_nxt != (PTR_W+1)'(DEPTH));
        out_valid_nxt = (count_nxt != '0);
        // A word written into the next head slot bypasses the array
        out_data_nxt  = (push && (wr_ptr_r == rd_ptr_nxt)) ? in_data : mem_r[rd_ptr_nxt];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            in_ready_r  <= 1'b1;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            count_r     <= count_nxt;
            in_ready_r  <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r  <= out_data_nxt;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule : capture_fifo

// Contract
// RL1: One new output word per converter clock.
// RL2: Sample taken at converter clock falling edge.
// RL3: Code appears 2.5 cycles plus delay later.
// RL4: Outputs change only after a rising edge.
// RL5: Conversion runs whatever the output enable.
// RL6: Drive outputs only while enable held low.
// RL7: Enable or power-down high means high impedance.
// RL8: Clamp to zeros below, ones above window.
// RL9: Each word carries eight result bits.
// RL10: Capture discards three words after restart.
module adc_sample_output_pipeline (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    conv_clock_run,
    input  wire adc_pipe_pkg::level_type analog_input,
    input  wire logic                    out_en_n,
    input  wire logic                    power_down_pin,
    output logic [`CODE_W-1:0]           data_out,
    output logic [`CODE_W-1:0]           data_oe_n,
    output logic                         cap_valid,
    input  wire logic                    cap_ready,
    output logic [`CODE_W-1:0]           cap_data,
    output logic                         cap_in_ready,
    output logic                         overrun,
    input  wire logic                    overrun_clear
);
    localparam int OD_CYC = `OUTPUT_DELAY_CYC;

    logic [`CONV_PHASE_W-1:0] phase_r;
    logic [`CONV_PHASE_W-1:0] phase_nxt;
    logic                     running;
    logic                     rise_en;
    logic                     fall_en;
    logic [OD_CYC-1:0]        rise_dly_r;
    logic [OD_CYC-1:0]        rise_dly_nxt;
    logic                     upd_en;
    adc_pipe_pkg::code_type   code_w;
    logic [23:0]              scaled;
    adc_pipe_pkg::code_type   stage0_r;
    adc_pipe_pkg::code_type   stage1_r;
    adc_pipe_pkg::code_type   stage2_r;
    adc_pipe_pkg::code_type   stage3_r;
    adc_pipe_pkg::code_type   stage0_nxt;
    adc_pipe_pkg::code_type   stage1_nxt;
    adc_pipe_pkg::code_type   stage2_nxt;
    adc_pipe_pkg::code_type   stage3_nxt;
    adc_pipe_pkg::code_type   data_out_r;
    adc_pipe_pkg::code_type   data_out_nxt;
    adc_pipe_pkg::code_type   data_oe_n_r;
    adc_pipe_pkg::code_type   data_oe_n_nxt;
    logic                     fifo_in_ready;
    logic                     fifo_push_r;
    logic                     fifo_push_nxt;
    logic                     overrun_r;
    logic                     overrun_nxt;

    // Converter runs only with its clock applied and out of power-down
    assign running = conv_clock_run && !power_down_pin;
    assign rise_en = running && (phase_r == `CONV_RISE_PHASE);
    assign fall_en = running && (phase_r == `CONV_FALL_PHASE);
    assign upd_en  = rise_dly_r[OD_CYC-1];

    // Divider; power-down parks it so the first edge after release is a rise
    always_comb begin
        if (power_down_pin) begin
            phase_nxt = `CONV_RISE_PHASE;
        end else if (conv_clock_run) begin
            phase_nxt = phase_r + 2'h1;
        end else begin
            phase_nxt = phase_r;
        end
        rise_dly_nxt = {rise_dly_r[OD_CYC-2:0], rise_en};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_r    <= `CONV_RISE_PHASE;
            rise_dly_r <= '0;
        end else begin
            phase_r    <= phase_nxt;
            rise_dly_r <= rise_dly_nxt;
        end
    end

    // Quantiser; constant divide trades area for a single-cycle result
    assign scaled = (24'(analog_input - `LEVEL_LOW) * `CODE_STEPS) / `LEVEL_SPAN;

    always_comb begin
        if (analog_input < `LEVEL_LOW) begin
            code_w = `CODE_ZERO;                            // [RL8]
        end else if (analog_input > `LEVEL_HIGH) begin
            code_w = `CODE_FULL;                            // [RL8]
        end else begin
            code_w = scaled[`CODE_W-1:0];                   // [RL9]
        end
    end

    // Sample on fall, then three rises to the output stage
    always_comb begin
        stage0_nxt = fall_en ? code_w : stage0_r;           // [RL2] [RL5]
        stage1_nxt = rise_en ? stage0_r : stage1_r;         // [RL3]
        stage2_nxt = rise_en ? stage1_r : stage2_r;
        stage3_nxt = rise_en ? stage2_r : stage3_r;
        data_out_nxt = upd_en ? stage3_r : data_out_r;      // [RL1] [RL4]
    end

    // Power-down flushes the pipeline; stale words read as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst || power_down_pin) begin
            stage0_r   <= `CODE_ZERO;
            stage1_r   <= `CODE_ZERO;
            stage2_r   <= `CODE_ZERO;
            stage3_r   <= `CODE_ZERO;
            data_out_r <= `CODE_ZERO;
        end else begin
            stage0_r   <= stage0_nxt;
            stage1_r   <= stage1_nxt;
            stage2_r   <= stage2_nxt;
            stage3_r   <= stage3_nxt;
            data_out_r <= data_out_nxt;
        end
    end

    // Pin enables; low enable means driven
    always_comb begin
        data_oe_n_nxt = (out_en_n || power_down_pin) ? `CODE_FULL : `CODE_ZERO; // [RL6] [RL7]
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            data_oe_n_r <= `CODE_FULL;
        end else begin
            data_oe_n_r <= data_oe_n_nxt;
        end
    end

    // Copy every presented word to the capture FIFO, one cycle behind the pin
    always_comb begin
        fifo_push_nxt = upd_en && !power_down_pin;
        if (fifo_push_r && !fifo_in_ready) begin
            overrun_nxt = 1'b1;                             // Set wins over clear
        end else if (overrun_clear) begin
            overrun_nxt = 1'b0;
        end else begin
            overrun_nxt = overrun_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fifo_push_r <= 1'b0;
            overrun_r   <= 1'b0;
        end else begin
            fifo_push_r <= fifo_push_nxt;
            overrun_r   <= overrun_nxt;
        end
    end

    // Words arriving while full are dropped and flagged; the converter never stalls
    capture_fifo #(
        .WIDTH (`CODE_W),
        .DEPTH (`FIFO_DEPTH),
        .PTR_W (`FIFO_PTR_W)
    ) u_capture_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (fifo_push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (data_out_r),
        .out_valid (cap_valid),
        .out_ready (cap_ready),
        .out_data  (cap_data)
    );

    assign data_out     = data_out_r;
    assign data_oe_n    = data_oe_n_r;
    assign cap_in_ready = fifo_in_ready;
    assign overrun      = overrun_r;

    // Output update follows every rise by the output delay
    a_rate_rise_update: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL1]
        rise_en |-> ##2 upd_en)
        else $error("update missing after rising edge");

    // No second update inside one converter period
    a_rate_single_word: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL1]
        upd_en |=> !upd_en [*3])
        else $error("two words in one period");

    // Sample stage loads the clamped code at the falling edge
    a_sample_at_fall: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL2]
        fall_en |=> stage0_r == $past(code_w))
        else $error("sample not taken at falling edge");

    // Code taken at a fall reaches the pins 13 system cycles later
    a_latency_exact: assert property (@(posedge sys_clk) // [RL3]
        disable iff (sys_rst || power_down_pin || !conv_clock_run)
        fall_en |-> ##13 data_out_r == $past(code_w, 13))
        else $error("pipeline latency wrong");

    // Pin word changes only on the delayed rising edge
    a_update_after_rise: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL4]
        (data_out_r != $past(data_out_r)) |-> $past(upd_en))
        else $error("output changed away from rising edge");

    // Disabled outputs do not stop sampling
    a_convert_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL5]
        (fall_en && out_en_n) |=> stage0_r == $past(code_w))
        else $error("conversion halted by output enable");

    // Pins driven only after enable low and power-down low
    a_drive_only_enabled: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL6]
        (data_oe_n_r == `CODE_ZERO) |-> $past(!out_en_n && !power_down_pin))
        else $error("pins driven while disabled");

    // Either control high floats all eight pins next cycle
    a_hiz_disable: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RL7]
        (out_en_n || power_down_pin) |=> data_oe_n_r == `CODE_FULL)
        else $error("pins not floated");

    // Below the window clamps to zeros
    a_clamp_low: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL8]
        (fall_en && analog_input < `LEVEL_LOW) |=> stage0_r == `CODE_ZERO)
        else $error("low clamp wrong");

    // Above three quarters clamps to full scale
    a_clamp_high: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL8]
        (fall_en && analog_input > `LEVEL_HIGH) |=> stage0_r == `CODE_FULL)
        else $error("high clamp wrong");

    // Whole eight-bit word moves from last stage to pins
    a_word_width: assert property (@(posedge sys_clk) disable iff (sys_rst || power_down_pin) // [RL9]
        upd_en |=> data_out_r == $past(stage3_r))
        else $error("output word corrupted");

    // Overrun flag keeps a drop that meets a clear
    a_overrun_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fifo_push_r && !fifo_in_ready) |=> overrun_r)
        else $error("overrun lost");
endmodule : adc_sample_output_pipeline

// ### design/adc_pipe_consts.svh
/*
 * Constants of the sampling converter pipeline: reference window, converter
 * clock divider, output delay and capture FIFO size.
 * Assumes a 100 MHz system clock; included by its bare name.
 */
`ifndef ADC_PIPE_CONSTS_SVH
`define ADC_PIPE_CONSTS_SVH

// System clock period in ns
`define SYS_CLK_PERIOD_NS  10
// Converter clock is the system clock divided by this (25 MHz)
`define CONV_DIV           4
`define CONV_PHASE_W       2
`define CONV_RISE_PHASE    2'h0
`define CONV_FALL_PHASE    2'h2
// Rising edge to data update; least time, rounded up
`define OUTPUT_DELAY_TIME_NS 14
`define OUTPUT_DELAY_CYC   ((`OUTPUT_DELAY_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
// Input level is a 16-bit fraction of the reference
`define LEVEL_W            16
`define CODE_W             8
// 0.0665 of reference and 3/4 of reference
`define LEVEL_LOW          16'h1106
`define LEVEL_HIGH         16'hC000
`define LEVEL_SPAN         24'h00AEFA
`define CODE_ZERO          8'h00
`define CODE_FULL          8'hFF
`define CODE_STEPS         24'h0000FF
// Capture FIFO
`define FIFO_DEPTH         8
`define FIFO_PTR_W         3

`endif

// ### design/adc_pipe_pkg.sv
/*
 * Types shared by the converter pipeline and its testbench.
 * Assumes the constants header is compiled alongside.
 */
`include "adc_pipe_consts.svh"

package adc_pipe_pkg;
    typedef logic [`CODE_W-1:0]  code_type;
    typedef logic [`LEVEL_W-1:0] level_type;
endpackage : adc_pipe_pkg

// ### test/capture_model.sv
/*
 * Capture logic on the far side of the converter FIFO: pops words with a
 * slow or stalled ready pattern and hands each kept word to the bench.
 * Assumes the FIFO handshake of the converter pipeline on sys_clk.
 */
`timescale 1ns/10ps
module capture_model (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       stall,
    input  wire logic       cap_valid,
    input  wire logic [7:0] cap_data,
    output logic            cap_ready,
    output logic            got,
    output logic [7:0]      got_data
);
    int         skip_cnt = 0;
    logic [1:0] pace_r   = 2'h0;

    // Two of three cycles ready; stall holds it off to fill the FIFO
    initial cap_ready = 1'b0;
    initial got       = 1'b0;
    always @(posedge sys_clk) begin
        got <= 1'b0;
        pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
        cap_ready <= !stall && (pace_r != 2'h0);
        if (sys_rst) begin
            skip_cnt <= 0;
        end else if (cap_valid && cap_ready) begin
            // Stale words right after restart are dropped, rest kept unsigned
            if (skip_cnt < 3) begin
                skip_cnt <= skip_cnt + 1;
            end else begin
                got      <= 1'b1;
                got_data <= cap_data;
            end
        end
    end
endmodule : capture_model

// ### test/adc_sample_output_pipeline_tb_top.sv
/*
 * Self-checking bench for the converter pipeline: random levels and enables,
 * power-down, clock stop and FIFO overflow.
 * Assumes the design files and the capture model are compiled first.
 */
`include "adc_pipe_consts.svh"
`timescale 1ns/10ps
module adc_sample_output_pipeline_tb_top;
    logic                    sys_clk        = 1'b0;
    logic                    sys_rst        = 1'b1;
    logic                    conv_clock_run = 1'b1;
    adc_pipe_pkg::level_type analog_input   = 16'h0000;
    logic                    out_en_n       = 1'b1;
    logic                    power_down_pin = 1'b0;
    logic                    overrun_clear  = 1'b0;
    logic                    stall          = 1'b0;
    logic                    fifo_cmp       = 1'b0;
    logic [31:0]             lfsr           = 32'h00011B73;
    logic [15:0]             corners [4]    = '{`LEVEL_LOW - 16'h1, `LEVEL_LOW, `LEVEL_HIGH, `LEVEL_HIGH + 16'h1};
    logic [7:0]              codes [512];
    logic [7:0]              exp_q [$];
    logic [7:0]              data_out, data_oe_n, cap_data, got_data, held;
    logic                    cap_valid, cap_ready, cap_in_ready, overrun, got;
    int                      err_count      = 0;
    int                      checks_done    = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    adc_sample_output_pipeline u_adc_sample_output_pipeline (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .conv_clock_run(conv_clock_run), .analog_input(analog_input),
        .out_en_n(out_en_n), .power_down_pin(power_down_pin), .data_out(data_out), .data_oe_n(data_oe_n),
        .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data), .cap_in_ready(cap_in_ready),
        .overrun(overrun), .overrun_clear(overrun_clear));

    capture_model u_capture_model (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall), .cap_valid(cap_valid), .cap_data(cap_data),
        .cap_ready(cap_ready), .got(got), .got_data(got_data));

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
        return lfsr;
    endfunction : next_rand

    // Ideal code: clamped outside the window, linear inside
    function automatic logic [7:0] exp_code(input logic [15:0] x);
        if (x < `LEVEL_LOW)
            return `CODE_ZERO;
        if (x > `LEVEL_HIGH)
            return `CODE_FULL;
        return 8'(((32'(x) - 32'(`LEVEL_LOW)) * 32'h000000FF) / 32'(`LEVEL_SPAN));
    endfunction : exp_code

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Eleven cycles of reset, idle state checked, released just after an edge
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        check("reset_state", {data_out, data_oe_n, cap_valid, cap_in_ready, overrun}, 19'h007FA);
        @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
    endtask : do_reset

    // Cycle 0 is the first after release; fall cycles are 2 mod 4
    task automatic run(input int n, input bit cmp);
        logic [31:0] r;
        logic        prev_en;
        int          u;
        prev_en  = out_en_n;
        fifo_cmp = cmp;
        for (int c = 0; c < n; c++) begin
            r = next_rand();
            analog_input = r[2] ? r[31:16] : corners[r[1:0]];
            codes[c % 512] = exp_code(analog_input);
            out_en_n = r[3];
            @(negedge sys_clk);
            if (c > 0) check("data_oe_n", data_oe_n, {8{prev_en}});
            if (c >= 15) begin
                u = c - ((c + 1) % 4);
                check("data_out", data_out, codes[(u - 13) % 512]);
                if (c % 4 == 3 && cmp)
                    exp_q.push_back(codes[(u - 13) % 512]);
            end
            prev_en = out_en_n;
            @(posedge sys_clk);
            #1;
        end
        fifo_cmp = 1'b0;
    endtask : run

    // Words popped by the capture model must follow the output stream
    always @(negedge sys_clk) begin
        if (got && fifo_cmp)
            check("cap_data", got_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end

    // Main sequence
    initial begin
        do_reset();
        run(200, 1'b1);
        $display("test random_stream done");
        out_en_n = 1'b0;
        power_down_pin = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            if (i > 0) check("power_down_oe_n", data_oe_n, 8'hFF);
            @(posedge sys_clk);
            #1;
        end
        power_down_pin = 1'b0;
        run(60, 1'b0);
        $display("test power_down done");
        // Stopped clock: pending update may land, then output must hold
        conv_clock_run = 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(negedge sys_clk);
            if (i == 3) held = data_out;
            if (i > 3) check("data_out_held", data_out, held);
            @(posedge sys_clk);
            #1;
        end
        conv_clock_run = 1'b1;
        do_reset();
        run(40, 1'b0);
        $display("test clock_stop done");
        // Overflow: consumer stalls past eight words, then drains
        stall = 1'b1;
        repeat (60) @(posedge sys_clk);
        @(negedge sys_clk);
        check("full_state", {cap_valid, cap_in_ready, overrun}, 3'h5);
        @(posedge sys_clk);
        #1;
        stall = 1'b0;
        for (int i = 0; i < 60 && cap_valid !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("drained", cap_valid, 1'b0);
        overrun_clear = 1'b1;
        @(posedge sys_clk);
        #1;
        overrun_clear = 1'b0;
        @(negedge sys_clk);
        check("cleared", {cap_in_ready, overrun}, 2'h2);
        $display("test overflow done");
        end_of_test();
    end

    // Watchdog far beyond the expected run of about 430 cycles
    initial begin
        #30000;
        err_count++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : adc_sample_output_pipeline_tb_top
